// ---- core/tmw_defs.svh ----
`ifndef TMW_DEFS_SVH
`define TMW_DEFS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define TMW_ADDR_CTRL 8'h00
`define TMW_ADDR_COUNT 8'h04
`define TMW_ADDR_CMPA 8'h08
`define TMW_ADDR_CMPB 8'h0C
`define TMW_ADDR_FLAGS 8'h10
`define TMW_ADDR_INTEN 8'h14
`define TMW_ADDR_DIR 8'h18

// ****************************************
// control fields
// ****************************************
`define TMW_F_WGM 2:0
`define TMW_F_OMA 5:4
`define TMW_F_OMB 7:6
`define TMW_F_CS 10:8
`define TMW_F_ASYNC 11
`define TMW_CTRL_W 12

// ****************************************
// flag bit positions
// ****************************************
`define TMW_FLG_OVF 0
`define TMW_FLG_CMPA 1
`define TMW_FLG_CMPB 2

// ****************************************
// reset values and extreme counts
// ****************************************
`define TMW_CTRL_RST 12'h000
`define TMW_BYTE_RST 8'h00
`define TMW_BOTTOM 8'h00
`define TMW_MAX 8'hFF

// ****************************************
// prescale masks (factor minus one)
// ****************************************
`define TMW_PS_1 10'h000
`define TMW_PS_8 10'h007
`define TMW_PS_32 10'h01F
`define TMW_PS_64 10'h03F
`define TMW_PS_128 10'h07F
`define TMW_PS_256 10'h0FF
`define TMW_PS_1024 10'h3FF

`endif

// ---- core/tmw_pkg.sv ----
`default_nettype none
package tmw_pkg;

  typedef enum logic [1:0] {KIND_NORM, KIND_CTC, KIND_FAST, KIND_PHASE} tmw_kind_e;

  // waveform mode select to counting behaviour
  function automatic tmw_kind_e kind_of(input logic [2:0] wgm);
    case (wgm)
      3'd2: kind_of = KIND_CTC;
      3'd3, 3'd7: kind_of = KIND_FAST;
      3'd1, 3'd5: kind_of = KIND_PHASE;
      default: kind_of = KIND_NORM;
    endcase
  endfunction

  // modes 2, 5 and 7 take TOP from compare A
  function automatic logic top_from_cmp(input logic [2:0] wgm);
    top_from_cmp = (wgm == 3'd5) || (wgm == 3'd7) || (wgm == 3'd2);
  endfunction

endpackage
`default_nettype wire

// ---- core/tmw_prescaler.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tmw_defs.svh"

module tmw_prescaler (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // selection
  input wire logic [2:0] clk_sel,
  input wire logic async_sel,
  input wire logic osc_level,
  // timer clock enable
  output logic tick
);

  logic osc_d_r;
  logic [9:0] div_r;
  logic src_en;
  logic [9:0] mask;

  function automatic logic [9:0] ps_mask(input logic [2:0] sel);
    case (sel)
      3'd1: ps_mask = `TMW_PS_1;
      3'd2: ps_mask = `TMW_PS_8;
      3'd3: ps_mask = `TMW_PS_32;
      3'd4: ps_mask = `TMW_PS_64;
      3'd5: ps_mask = `TMW_PS_128;
      3'd6: ps_mask = `TMW_PS_256;
      default: ps_mask = `TMW_PS_1024;
    endcase
  endfunction

  // rising oscillator edges become enables so everything stays on pclk
  assign src_en = async_sel ? (osc_level & ~osc_d_r) : 1'b1; // RQ20
  assign mask = ps_mask(clk_sel);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_d_r <= 1'b0;
    end else begin
      osc_d_r <= osc_level;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 10'h000;
    end else if (src_en) begin
      div_r <= div_r + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 1'b0;
    end else begin
      tick <= src_en && (clk_sel != 3'd0) && ((div_r & mask) == mask); // RQ7
    end
  end

endmodule
`default_nettype wire

// ---- core/tmw_wavegen.sv ----
`timescale 1ns/10ps
`default_nettype none

module tmw_wavegen (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // mode
  input wire tmw_pkg::tmw_kind_e kind,
  input wire logic [1:0] out_mode,
  // events qualified by the timer tick, plus the unqualified direction and compare status
  input wire logic match,
  input wire logic wrap_ev,
  input wire logic turn_ev,
  input wire logic up_eff,
  input wire logic leave_top,
  // internal waveform level
  output logic wave
);

  logic up_hit_r;

  // remembers whether the up slope produced its match
  // held clear outside phase-correct so a match from another mode cannot suppress the forced level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_hit_r <= 1'b0;
    end else if (turn_ev || kind != tmw_pkg::KIND_PHASE) begin
      up_hit_r <= 1'b0;
    end else if (match && up_eff) begin
      up_hit_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave <= 1'b0;
    end else begin
      case (kind)
        tmw_pkg::KIND_FAST: begin
          // bottom has priority so compare at MAX holds the level
          if (wrap_ev && out_mode[1]) begin
            wave <= ~out_mode[0]; // RQ10 RQ12
          end else if (match && out_mode == 2'd1) begin
            wave <= ~wave; // RQ13
          end else if (match && out_mode[1]) begin
            wave <= out_mode[0]; // RQ10
          end
        end
        tmw_pkg::KIND_PHASE: begin
          if (turn_ev && leave_top && !up_hit_r && out_mode[1]) begin
            wave <= out_mode[0]; // RQ19
          end else if (match && out_mode[1]) begin
            wave <= up_eff ? out_mode[0] : ~out_mode[0]; // RQ16 RQ18
          end
        end
        default: begin
          if (match) begin
            case (out_mode)
              2'd1: wave <= ~wave; // RQ4
              2'd2: wave <= 1'b0;
              2'd3: wave <= 1'b1;
              default: wave <= wave;
            endcase
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- core/tmw_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tmw_defs.svh"

// Summary of operation
// RQ1: mode 2 counts up and clears to zero on compare A match.
// RQ2: clear-on-match sets compare A flag at TOP, with interrupt request if enabled.
// RQ3: no buffering there; a compare below count is missed until wrap.
// RQ4: clear-on-match output mode 1 toggles output A on every match.
// RQ5: waveform reaches pin only when direction bit selects output.
// RQ6: clear-on-match sets overflow flag as count rolls MAX to zero.
// RQ7: timer clock is I/O clock over 1, 8, 32, 64, 128, 256 or 1024.
// RQ8: modes 3 and 7 count single slope; TOP is MAX or compare A.
// RQ9: fast PWM clears counter on the tick after it equals TOP.
// RQ10: fast PWM mode two clears on match, sets at bottom; three inverts.
// RQ11: fast PWM sets overflow flag whenever count reaches TOP.
// RQ12: fast PWM compare zero gives spike; compare MAX gives constant level.
// RQ13: fast PWM output mode 1 toggles on match, compare still buffered.
// RQ14: modes 1 and 5 count dual slope up then down repeatedly.
// RQ15: phase-correct holds TOP one timer clock, then reverses direction.
// RQ16: phase-correct non-inverting clears on up match, sets on down match.
// RQ17: phase-correct sets overflow flag whenever count reaches bottom.
// RQ18: phase-correct compare bottom gives constant low, MAX constant high.
// RQ19: phase-correct forces the up-match transition when the match was missed.
// RQ20: prescaled timer clock is an enable; async mode uses oscillator.
// RQ21: phase-correct TOP is MAX in mode 1, compare A in mode 5.
// RQ22: PWM modes buffer compare values; other modes write them directly.
// RQ23: compare flag sets one tick after equality; writing one clears it.
module tmw_timer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer oscillator level for asynchronous operation
  input wire logic osc_level,
  // ordinary port data for the two pins
  input wire logic port_a_data,
  input wire logic port_b_data,
  // pins
  output logic pin_a_o,
  output logic pin_a_oe,
  output logic pin_b_o,
  output logic pin_b_oe,
  // interrupt requests: overflow, compare a, compare b
  output logic [2:0] irq_req
);

  // ****************************************
  // registers
  // ****************************************
  logic [`TMW_CTRL_W-1:0] ctrl_r;
  logic [7:0] cnt_r;
  logic [7:0] cmpa_buf_r;
  logic [7:0] cmpa_r;
  logic [7:0] cmpb_buf_r;
  logic [7:0] cmpb_r;
  logic [2:0] flag_r;
  logic [2:0] inten_r;
  logic [1:0] dir_r;
  logic up_r;
  logic block_r;

  logic tick;
  logic wave_a;
  logic wave_b;
  tmw_pkg::tmw_kind_e kind;
  logic pwm;
  logic [7:0] top;
  logic [7:0] top_next;
  logic at_top;
  logic up_eff;
  logic [7:0] cnt_nxt;
  logic wr_en;
  logic wr_ctrl;
  logic wr_cnt;
  logic wr_cmpa;
  logic wr_cmpb;
  logic wr_flags;
  logic wr_inten;
  logic wr_dir;
  logic match_a;
  logic match_b;
  logic ovf_ev;
  logic wrap_ev;
  logic turn_ev;
  logic [2:0] flag_set;

  // compare register update: direct outside PWM, at TOP inside PWM
  function automatic logic [7:0] cmp_next(input logic [7:0] cur, input logic [7:0] buffered,
                                          input logic wr, input logic [7:0] wdata,
                                          input logic is_pwm, input logic upd);
    if (!is_pwm) begin
      cmp_next = wr ? wdata : buffered;
    end else if (upd) begin
      cmp_next = buffered;
    end else begin
      cmp_next = cur;
    end
  endfunction

  // ****************************************
  // apb decode
  // ****************************************
  // writes land at the access edge; pready is a flop so no wait states
  assign wr_en = psel & penable & pready & pwrite;
  assign wr_ctrl = wr_en && (paddr == `TMW_ADDR_CTRL);
  assign wr_cnt = wr_en && (paddr == `TMW_ADDR_COUNT);
  assign wr_cmpa = wr_en && (paddr == `TMW_ADDR_CMPA);
  assign wr_cmpb = wr_en && (paddr == `TMW_ADDR_CMPB);
  assign wr_flags = wr_en && (paddr == `TMW_ADDR_FLAGS);
  assign wr_inten = wr_en && (paddr == `TMW_ADDR_INTEN);
  assign wr_dir = wr_en && (paddr == `TMW_ADDR_DIR);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
    end
  end

  // read data is captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      case (paddr)
        `TMW_ADDR_CTRL: prdata <= {20'h0_0000, ctrl_r};
        `TMW_ADDR_COUNT: prdata <= {24'h00_0000, cnt_r};
        `TMW_ADDR_CMPA: prdata <= {24'h00_0000, cmpa_buf_r};
        `TMW_ADDR_CMPB: prdata <= {24'h00_0000, cmpb_buf_r};
        `TMW_ADDR_FLAGS: prdata <= {29'h000_0000, flag_r};
        `TMW_ADDR_INTEN: prdata <= {29'h000_0000, inten_r};
        `TMW_ADDR_DIR: prdata <= {30'h000_0000, dir_r};
        default: begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `TMW_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= pwdata[`TMW_CTRL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inten_r <= 3'h0;
      dir_r <= 2'h0;
    end else begin
      if (wr_inten) begin
        inten_r <= pwdata[2:0];
      end
      if (wr_dir) begin
        dir_r <= pwdata[1:0];
      end
    end
  end

  // ****************************************
  // timer clock
  // ****************************************
  tmw_prescaler u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .clk_sel(ctrl_r[`TMW_F_CS]),
    .async_sel(ctrl_r[`TMW_F_ASYNC]),
    .osc_level(osc_level),
    .tick(tick)
  );

  // ****************************************
  // counting sequence
  // ****************************************
  assign kind = tmw_pkg::kind_of(ctrl_r[`TMW_F_WGM]);
  assign pwm = (kind == tmw_pkg::KIND_FAST) || (kind == tmw_pkg::KIND_PHASE);
  assign top = tmw_pkg::top_from_cmp(ctrl_r[`TMW_F_WGM]) ? cmpa_r : `TMW_MAX; // RQ1 RQ8 RQ21
  assign top_next = tmw_pkg::top_from_cmp(ctrl_r[`TMW_F_WGM]) ? cmpa_buf_r : `TMW_MAX;
  assign at_top = (cnt_r == top);
  // bottom always turns upward, TOP turns downward unless TOP is also bottom
  assign up_eff = (cnt_r == `TMW_BOTTOM) ? 1'b1 : (at_top ? 1'b0 : up_r); // RQ14 RQ15

  always_comb begin
    case (kind)
      tmw_pkg::KIND_CTC: cnt_nxt = at_top ? `TMW_BOTTOM : cnt_r + 8'h01; // RQ1 RQ3
      tmw_pkg::KIND_FAST: cnt_nxt = at_top ? `TMW_BOTTOM : cnt_r + 8'h01; // RQ8 RQ9
      tmw_pkg::KIND_PHASE: cnt_nxt = up_eff ? cnt_r + 8'h01 : cnt_r - 8'h01; // RQ14 RQ15
      default: cnt_nxt = cnt_r + 8'h01;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= `TMW_BYTE_RST;
    end else if (wr_cnt) begin
      cnt_r <= pwdata[7:0];
    end else if (tick) begin
      cnt_r <= cnt_nxt; // RQ20
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_r <= 1'b1;
    end else if (tick) begin
      up_r <= (kind == tmw_pkg::KIND_PHASE) ? up_eff : 1'b1;
    end
  end

  // a count write hides any match in the following timer clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_r <= 1'b0;
    end else if (wr_cnt) begin
      block_r <= 1'b1;
    end else if (tick) begin
      block_r <= 1'b0;
    end
  end

  // ****************************************
  // compare registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpa_buf_r <= `TMW_BYTE_RST;
      cmpb_buf_r <= `TMW_BYTE_RST;
    end else begin
      if (wr_cmpa) begin
        cmpa_buf_r <= pwdata[7:0];
      end
      if (wr_cmpb) begin
        cmpb_buf_r <= pwdata[7:0];
      end
    end
  end

  // buffered copies move at TOP, which is where fast PWM wraps to bottom
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpa_r <= `TMW_BYTE_RST;
      cmpb_r <= `TMW_BYTE_RST;
    end else begin
      cmpa_r <= cmp_next(cmpa_r, cmpa_buf_r, wr_cmpa, pwdata[7:0], pwm, tick & at_top); // RQ22 RQ3
      cmpb_r <= cmp_next(cmpb_r, cmpb_buf_r, wr_cmpb, pwdata[7:0], pwm, tick & at_top); // RQ22
    end
  end

  // ****************************************
  // events and flags
  // ****************************************
  assign match_a = tick && !block_r && (cnt_r == cmpa_r);
  assign match_b = tick && !block_r && (cnt_r == cmpb_r);
  assign wrap_ev = tick && at_top && (kind == tmw_pkg::KIND_FAST);
  assign turn_ev = tick && at_top && (kind == tmw_pkg::KIND_PHASE);

  always_comb begin
    case (kind)
      tmw_pkg::KIND_FAST: ovf_ev = tick && at_top; // RQ11
      tmw_pkg::KIND_PHASE: ovf_ev = tick && (cnt_r == `TMW_BOTTOM) && !up_r; // RQ17
      default: ovf_ev = tick && (cnt_r == `TMW_MAX); // RQ6
    endcase
  end

  assign flag_set = {match_b, match_a, ovf_ev}; // RQ2 RQ23

  // setting wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 3'h0;
    end else begin
      flag_r <= (flag_r & ~(wr_flags ? pwdata[2:0] : 3'h0)) | flag_set; // RQ23
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 3'h0;
    end else begin
      irq_req <= flag_r & inten_r; // RQ2
    end
  end

  // ****************************************
  // waveform generation
  // ****************************************
  tmw_wavegen u_wave_a (
    .pclk(pclk),
    .presetn(presetn),
    .kind(kind),
    .out_mode(ctrl_r[`TMW_F_OMA]),
    .match(match_a),
    .wrap_ev(wrap_ev),
    .turn_ev(turn_ev),
    .up_eff(up_eff),
    .leave_top(cmpa_buf_r != top_next),
    .wave(wave_a)
  );

  tmw_wavegen u_wave_b (
    .pclk(pclk),
    .presetn(presetn),
    .kind(kind),
    .out_mode(ctrl_r[`TMW_F_OMB]),
    .match(match_b),
    .wrap_ev(wrap_ev),
    .turn_ev(turn_ev),
    .up_eff(up_eff),
    .leave_top(cmpb_buf_r != top_next),
    .wave(wave_b)
  );

  // ****************************************
  // pin override
  // ****************************************
  // any nonzero output mode takes the pin; the driver still needs its direction bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a_o <= 1'b0;
      pin_a_oe <= 1'b0;
      pin_b_o <= 1'b0;
      pin_b_oe <= 1'b0;
    end else begin
      pin_a_o <= (ctrl_r[`TMW_F_OMA] != 2'd0) ? wave_a : port_a_data; // RQ5
      pin_a_oe <= dir_r[0]; // RQ5
      pin_b_o <= (ctrl_r[`TMW_F_OMB] != 2'd0) ? wave_b : port_b_data;
      pin_b_oe <= dir_r[1];
    end
  end

endmodule
`default_nettype wire

// ---- tb/tmw_timer_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module tmw_timer_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and requests
  input wire logic pin_a_oe,
  input wire logic pin_b_oe,
  input wire logic [2:0] irq_req
);
  wire setup = psel && !penable;
  wire wr_done = psel && penable && pready && pwrite;
  wire mapped = (paddr <= 8'h18) && (paddr[1:0] == 2'b00);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_answer; setup |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  property p_idle; !setup |=> !pready; endproperty
  a_idle: assert property (p_idle) else $error("ready without setup");
  property p_err; pready |-> (pslverr == !mapped); endproperty
  a_err: assert property (p_err) else $error("slave error does not match address");
  property p_zero; pready && pslverr |-> (prdata == 32'h0000_0000); endproperty
  a_zero: assert property (p_zero) else $error("refused read returns data");
  property p_upper; pready && !pslverr |-> (prdata[31:12] == 20'h0_0000); endproperty
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  property p_hold; !setup |=> $stable(prdata) && $stable(pslverr); endproperty
  a_hold: assert property (p_hold) else $error("read data moved outside setup");
  property p_dir; wr_done && paddr == 8'h18 |=> ##1 ({pin_b_oe, pin_a_oe} == $past(pwdata[1:0], 2)); endproperty
  a_dir: assert property (p_dir) else $error("pin enables do not follow direction");
  // flags are sticky, so a request only drops after a flag clear or a mask write
  property p_sticky; ($past(irq_req) & ~irq_req) != 3'b000 |->
    $past(wr_done && (paddr == 8'h10 || paddr == 8'h14), 2); endproperty
  a_sticky: assert property (p_sticky) else $error("request dropped on its own");
endmodule
bind tmw_timer tmw_timer_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .pin_a_oe, .pin_b_oe, .irq_req);
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tmw_defs.svh"
module testbench;
  // ****************
  // signals
  // ****************
  logic pclk, presetn, psel, penable, pwrite, osc_level, port_a_data, port_b_data;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic pready, pslverr, pin_a_o, pin_a_oe, pin_b_o, pin_b_oe, re;
  logic [2:0] irq_req;
  int err_count = 0;
  int n_tests = 0;
  int hi, per, c;
  typedef struct {logic [11:0] ctrl; logic [7:0] ca; logic [7:0] cb; logic b; int hi; int per; logic lv;} tmw_row_s;
  tmw_row_s rows [13] = '{
    '{12'h112, 8'h03, 8'h00, 1'b0, 4, 8, 1'b0},
    '{12'h123, 8'h40, 8'h00, 1'b0, 65, 256, 1'b0},
    '{12'h133, 8'h40, 8'h00, 1'b0, 191, 256, 1'b0},
    '{12'h123, 8'h00, 8'h00, 1'b0, 1, 256, 1'b0},
    '{12'h123, 8'hFF, 8'h00, 1'b0, 0, 0, 1'b1},
    '{12'h117, 8'h09, 8'h00, 1'b0, 10, 20, 1'b0},
    '{12'h187, 8'h1F, 8'h08, 1'b1, 9, 32, 1'b0},
    '{12'h121, 8'h40, 8'h00, 1'b0, 128, 510, 1'b0},
    '{12'h131, 8'h40, 8'h00, 1'b0, 382, 510, 1'b0},
    '{12'h185, 8'h20, 8'h10, 1'b1, 32, 64, 1'b0},
    '{12'h121, 8'h00, 8'h00, 1'b0, 0, 0, 1'b0},
    '{12'h121, 8'hFF, 8'h00, 1'b0, 0, 0, 1'b1},
    '{12'h912, 8'h00, 8'h00, 1'b0, 6, 12, 1'b0}};
  int fac [7] = '{1, 8, 32, 64, 128, 256, 1024};
  logic [11:0] ovc [3] = '{12'h107, 12'h105, 12'h102};

  tmw_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_level(osc_level), .port_a_data(port_a_data), .port_b_data(port_b_data), .pin_a_o(pin_a_o),
    .pin_a_oe(pin_a_oe), .pin_b_o(pin_b_o), .pin_b_oe(pin_b_oe), .irq_req(irq_req));

  // ****************
  // tasks
  // ****************
  task automatic summarize;
    $display("mismatches %0d, checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, n < 20}, 32'h0000_0001, "ready");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // compare values are written in normal mode, where they land directly
  task automatic cfg(input logic [11:0] ctrl, input logic [7:0] ca, input logic [7:0] cb);
    wr(`TMW_ADDR_CTRL, 32'h0000_0000);
    wr(`TMW_ADDR_COUNT, 32'h0000_0000);
    wr(`TMW_ADDR_CMPA, {24'h00_0000, ca});
    wr(`TMW_ADDR_CMPB, {24'h00_0000, cb});
    wr(`TMW_ADDR_FLAGS, 32'h0000_0007);
    wr(`TMW_ADDR_CTRL, {20'h0_0000, ctrl});
  endtask

  // high time and period from one rising edge of a pin to the next; period 0 means no full cycle was seen
  task automatic meas(input logic b, output int h, output int p);
    int ph;
    logic q, v;
    ph = 0;
    h = 0;
    p = 0;
    q = 1'b1;
    repeat (600) @(posedge pclk);
    repeat (4500) begin
      @(posedge pclk);
      v = b ? pin_b_o : pin_a_o;
      if (ph == 2 && v === 1'b1) begin
        ph = 3;
        break;
      end
      if (ph == 1 && v === 1'b0) ph = 2;
      if (ph == 0 && q === 1'b0 && v === 1'b1) ph = 1;
      if (ph != 0) p++;
      if (ph == 1) h++;
      q = v;
    end
    if (ph != 3) begin
      h = 0;
      p = 0;
    end
  endtask

  // ****************
  // clock, oscillator, watchdog
  // ****************
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    osc_level = 1'b0;
    forever begin
      repeat (3) @(posedge pclk);
      osc_level <= ~osc_level;
    end
  end

  initial begin
    repeat (100000) @(posedge pclk);
    err_count++;
    summarize();
  end

  // ****************
  // tests
  // ****************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    port_a_data = 1'b0;
    port_b_data = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(8'(4 * i));
      chk(rq, 32'h0000_0000, "reset value");
      chk({31'h0, re}, {31'h0, i == 7}, "slave error");
    end
    wr(`TMW_ADDR_INTEN, 32'h0000_0007);
    wr(`TMW_ADDR_DIR, 32'h0000_0003);
    foreach (rows[i]) begin
      cfg(rows[i].ctrl, rows[i].ca, rows[i].cb);
      meas(rows[i].b, hi, per);
      chk(hi, rows[i].hi, "high time");
      chk(per, rows[i].per, "period");
      if (rows[i].per == 0) chk({31'h0, rows[i].b ? pin_b_o : pin_a_o}, {31'h0, rows[i].lv}, "level");
    end
    for (int k = 1; k < 8; k++) begin
      cfg({1'b0, 3'(k), 8'h12}, 8'h00, 8'h00);
      meas(1'b0, hi, per);
      chk(per, 2 * fac[k - 1], "prescaled period");
    end
    // a compare below the count is only met after the wrap
    wr(`TMW_ADDR_CTRL, 32'h0000_0000);
    wr(`TMW_ADDR_COUNT, 32'h0000_000A);
    wr(`TMW_ADDR_CMPA, 32'h0000_0005);
    wr(`TMW_ADDR_FLAGS, 32'h0000_0007);
    wr(`TMW_ADDR_CTRL, 32'h0000_0102);
    c = 0;
    while (irq_req[1] !== 1'b1 && c < 400) begin
      @(posedge pclk);
      c++;
    end
    chk({31'h0, irq_req[0]}, 32'h0000_0001, "overflow before match");
    chk({31'h0, c > 244 && c < 262}, 32'h0000_0001, "missed match delay");
    wr(`TMW_ADDR_CTRL, 32'h0000_0000);
    wr(`TMW_ADDR_FLAGS, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    chk({29'h0, irq_req}, 32'h0000_0005, "flag clear");
    for (int j = 0; j < 3; j++) begin
      cfg(ovc[j], 8'h09, 8'h00);
      repeat (40) @(posedge pclk);
      chk({31'h0, irq_req[0]}, {31'h0, j < 2}, "overflow flag");
    end
    // a compare written in PWM mode waits in its buffer until TOP
    cfg(12'h023, 8'h40, 8'h00);
    wr(`TMW_ADDR_CMPA, 32'h0000_0020);
    wr(`TMW_ADDR_COUNT, 32'h0000_0030);
    wr(`TMW_ADDR_CTRL, 32'h0000_0123);
    repeat (30) @(posedge pclk);
    chk({31'h0, irq_req[1]}, 32'h0000_0001, "buffered compare");
    // compare leaving MAX forces the up-slope level at TOP
    cfg(12'h121, 8'hFF, 8'h00);
    repeat (600) @(posedge pclk);
    wr(`TMW_ADDR_CMPA, 32'h0000_0010);
    c = 0;
    while (pin_a_o !== 1'b0 && c < 700) begin
      @(posedge pclk);
      c++;
    end
    hi = 0;
    while (pin_a_o !== 1'b1 && hi < 700) begin
      @(posedge pclk);
      hi++;
    end
    chk(hi, 239, "forced low time");
    cfg(12'h000, 8'h00, 8'h00);
    port_a_data <= 1'b1;
    wr(`TMW_ADDR_DIR, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk({28'h000_0000, pin_b_oe, pin_a_oe, pin_b_o, pin_a_o}, 32'h0000_0005, "port function");
    port_a_data <= 1'b0;
    port_b_data <= 1'b1;
    wr(`TMW_ADDR_DIR, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    chk({28'h000_0000, pin_b_oe, pin_a_oe, pin_b_o, pin_a_o}, 32'h0000_000A, "port function");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({25'h0, pin_a_o, pin_a_oe, pin_b_oe, irq_req, pready}, 32'h0000_0000, "reset outputs");
    presetn <= 1'b1;
    rd(`TMW_ADDR_DIR);
    chk(rq, 32'h0000_0000, "direction after reset");
    summarize();
  end
endmodule
`default_nettype wire
